// >>> rtl/cbt_host.sv
// Host controller end: issues block reads and writes per program scan.
// Assumes user go levels stay high until the matching done pulse.
// Also holds the read return FIFO that the slave end instantiates.
`timescale 1ns/1ps
`include "cbt_defs.svh"

module cbt_fifo #(
  parameter int W     = 16,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input  wire logic         mclk,
  input  wire logic         resetn,
  // Fill side
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  // Drain side
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0] mem [DEPTH];
  logic [AW-1:0] wptr_ff;
  logic [AW-1:0] rptr_ff;
  logic [AW:0]   count_ff;
  logic          push;
  logic          pop;

  // Honest flags from the fill count
  assign in_ready  = count_ff != (AW+1)'(DEPTH);
  assign out_valid = count_ff != '0;
  assign out_data  = mem[rptr_ff];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  // Storage
  always_ff @(posedge mclk) begin
    if (push) begin
      mem[wptr_ff] <= in_data;
    end
  end

  // Pointers and fill count
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      wptr_ff  <= '0;
      rptr_ff  <= '0;
      count_ff <= '0;
    end else begin
      if (push) begin
        wptr_ff <= wptr_ff + 1'b1;
      end
      if (pop) begin
        rptr_ff <= rptr_ff + 1'b1;
      end
      count_ff <= count_ff + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

module cbt_host import cbt_pkg::*; (
  // Link to the slave module
  cbt_if.host              link,
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        resetn,
  // Scan and target
  input  wire logic        scan_tick,
  input  wire logic [11:0] head_io_num,
  // User read port
  input  wire logic        usr_rd_go,
  input  wire cbt_word_t   usr_rd_off,
  input  wire cbt_word_t   usr_rd_cnt,
  input  wire logic        out_module_present,
  output cbt_word_t        usr_rd_data,
  output logic             usr_rd_valid,
  input  wire logic        usr_rd_ready,
  output logic             usr_rd_done,
  output cbt_stat_t        usr_rd_stat,
  // User write port
  input  wire logic        usr_wr_go,
  input  wire cbt_word_t   usr_wr_off,
  input  wire cbt_word_t   usr_wr_cnt,
  input  wire logic        in_module_present,
  input  wire cbt_word_t   usr_wr_data,
  input  wire logic        usr_wr_valid,
  output logic             usr_wr_ready,
  output logic             usr_wr_done,
  output cbt_stat_t        usr_wr_stat
);
  cbt_h_st_t  hr_st_ff, hw_st_ff;
  logic       rd_sr_ff, wr_sr_ff, rd_req_ff, wr_req_ff, rd_used_ff, wr_used_ff;
  logic [7:0] rd_sel_ff, wr_sel_ff;
  cbt_word_t  rd_off_ff, rd_cnt_ff, wr_off_ff, wr_cnt_ff, wr_left_ff;
  logic       rd_ready_ff, usr_rd_valid_ff, usr_rd_done_ff;
  logic       wr_valid_ff, usr_wr_ready_ff, usr_wr_done_ff;
  cbt_word_t  usr_rd_data_ff, wr_data_ff;
  cbt_stat_t  usr_rd_stat_ff, usr_wr_stat_ff;
  logic       rd_issue, wr_issue, rd_take, wr_take;

  // One attempt per direction per scan
  assign rd_issue = (hr_st_ff == CBT_H_START && link.rd_accept_complete) ||
                    (hr_st_ff == CBT_H_IDLE && usr_rd_go && !rd_used_ff && !out_module_present);
  assign wr_issue = (hw_st_ff == CBT_H_START && link.wr_accept_complete) ||
                    (hw_st_ff == CBT_H_IDLE && usr_wr_go && !wr_used_ff && !in_module_present);
  assign rd_take  = link.rd_valid && rd_ready_ff;
  assign wr_take  = usr_wr_valid && usr_wr_ready_ff;

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      rd_used_ff <= 1'b0;
      wr_used_ff <= 1'b0;
    end else begin
      rd_used_ff <= rd_issue || (rd_used_ff && !scan_tick);
      wr_used_ff <= wr_issue || (wr_used_ff && !scan_tick);
    end
  end

  // Read sequencer; a refused try ends with usr_rd_done and its verdict in usr_rd_stat
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      hr_st_ff <= CBT_H_IDLE;
      rd_sr_ff <= 1'b0;
      rd_req_ff <= 1'b0;
      rd_sel_ff <= '0;
      rd_off_ff <= '0;
      rd_cnt_ff <= '0;
      usr_rd_done_ff <= 1'b0;
      usr_rd_stat_ff <= CBT_OK;
    end else begin
      usr_rd_done_ff <= 1'b0;
      rd_req_ff <= 1'b0;
      case (hr_st_ff)
        CBT_H_IDLE: begin
          if (usr_rd_go && !rd_used_ff) begin
            if (!out_module_present) begin
              usr_rd_done_ff <= 1'b1;
              usr_rd_stat_ff <= CBT_SKIP;
            end else begin
              rd_sr_ff <= 1'b1;
              hr_st_ff <= CBT_H_START;
            end
          end
        end
        CBT_H_START: begin
          if (link.rd_accept_complete) begin
            rd_req_ff <= 1'b1;
            rd_sel_ff <= head_io_num[11:4];
            rd_off_ff <= usr_rd_off;
            rd_cnt_ff <= usr_rd_cnt;
            hr_st_ff  <= CBT_H_REQ;
          end
        end
        CBT_H_REQ: hr_st_ff <= CBT_H_RUN;
        CBT_H_RUN: begin
          if (link.rd_done) begin
            usr_rd_done_ff <= 1'b1;
            usr_rd_stat_ff <= link.rd_stat;
            rd_sr_ff <= 1'b0;
            hr_st_ff <= CBT_H_END;
          end
        end
        default: begin
          if (!link.rd_accept_complete) begin
            hr_st_ff <= CBT_H_IDLE;
          end
        end
      endcase
    end
  end

  // Read word holding register toward the user
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      usr_rd_data_ff  <= '0;
      usr_rd_valid_ff <= 1'b0;
      rd_ready_ff     <= 1'b0;
    end else if (rd_take) begin
      usr_rd_data_ff  <= link.rd_data;
      usr_rd_valid_ff <= 1'b1;
      rd_ready_ff     <= 1'b0;
    end else begin
      if (usr_rd_valid_ff && usr_rd_ready) begin
        usr_rd_valid_ff <= 1'b0;
      end
      rd_ready_ff <= (hr_st_ff == CBT_H_RUN) && (!usr_rd_valid_ff || usr_rd_ready);
    end
  end

  // Write sequencer
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      hw_st_ff <= CBT_H_IDLE;
      wr_sr_ff <= 1'b0;
      wr_req_ff <= 1'b0;
      wr_sel_ff <= '0;
      wr_off_ff <= '0;
      wr_cnt_ff <= '0;
      usr_wr_done_ff <= 1'b0;
      usr_wr_stat_ff <= CBT_OK;
    end else begin
      usr_wr_done_ff <= 1'b0;
      wr_req_ff <= 1'b0;
      case (hw_st_ff)
        CBT_H_IDLE: begin
          if (usr_wr_go && !wr_used_ff) begin
            if (!in_module_present) begin
              usr_wr_done_ff <= 1'b1;
              usr_wr_stat_ff <= CBT_SKIP;
            end else begin
              wr_sr_ff <= 1'b1;
              hw_st_ff <= CBT_H_START;
            end
          end
        end
        CBT_H_START: begin
          if (link.wr_accept_complete) begin
            wr_req_ff <= 1'b1;
            wr_sel_ff <= head_io_num[11:4];
            wr_off_ff <= usr_wr_off;
            wr_cnt_ff <= usr_wr_cnt;
            hw_st_ff  <= CBT_H_REQ;
          end
        end
        CBT_H_REQ: hw_st_ff <= CBT_H_RUN;
        CBT_H_RUN: begin
          if (link.wr_done) begin
            usr_wr_done_ff <= 1'b1;
            usr_wr_stat_ff <= link.wr_stat;
            wr_sr_ff <= 1'b0;
            hw_st_ff <= CBT_H_END;
          end
        end
        default: begin
          if (!link.wr_accept_complete) begin
            hw_st_ff <= CBT_H_IDLE;
          end
        end
      endcase
    end
  end

  // Write word holding register toward the module
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      wr_data_ff      <= '0;
      wr_valid_ff     <= 1'b0;
      usr_wr_ready_ff <= 1'b0;
      wr_left_ff      <= '0;
    end else if (hw_st_ff == CBT_H_START) begin
      wr_left_ff  <= usr_wr_cnt;
      wr_valid_ff <= 1'b0;
    end else if (hw_st_ff != CBT_H_RUN) begin
      wr_valid_ff     <= 1'b0;
      usr_wr_ready_ff <= 1'b0;
    end else if (wr_take) begin
      wr_data_ff      <= usr_wr_data;
      wr_valid_ff     <= 1'b1;
      usr_wr_ready_ff <= 1'b0;
      wr_left_ff      <= wr_left_ff - 16'h0001;
    end else begin
      if (wr_valid_ff && link.wr_ready) begin
        wr_valid_ff <= 1'b0;
      end
      usr_wr_ready_ff <= (wr_left_ff != 16'h0000) && (!wr_valid_ff || link.wr_ready);
    end
  end

  // Output wiring
  assign link.rd_start_request = rd_sr_ff;
  assign link.wr_start_request = wr_sr_ff;
  assign link.rd_req           = rd_req_ff;
  assign link.rd_module_select = rd_sel_ff;
  assign link.rd_head_offset   = rd_off_ff;
  assign link.rd_word_count    = rd_cnt_ff;
  assign link.rd_ready         = rd_ready_ff;
  assign link.wr_req           = wr_req_ff;
  assign link.wr_module_select = wr_sel_ff;
  assign link.wr_head_offset   = wr_off_ff;
  assign link.wr_word_count    = wr_cnt_ff;
  assign link.wr_data          = wr_data_ff;
  assign link.wr_valid         = wr_valid_ff;
  assign usr_rd_data           = usr_rd_data_ff;
  assign usr_rd_valid          = usr_rd_valid_ff;
  assign usr_rd_done           = usr_rd_done_ff;
  assign usr_rd_stat           = usr_rd_stat_ff;
  assign usr_wr_ready          = usr_wr_ready_ff;
  assign usr_wr_done           = usr_wr_done_ff;
  assign usr_wr_stat           = usr_wr_stat_ff;
endmodule

// >>> rtl/cbt_defs.svh
// Constants of the consistent block transfer pair.
// Included by the package and by the host and slave module files.
`ifndef CBT_DEFS_SVH
`define CBT_DEFS_SVH
`define CBT_WORD_W     16
`define CBT_AREA_WORDS 122
`define CBT_IDX_W      7
`define CBT_FIFO_DEPTH 16
`define CBT_SEL_MAX    8'hfe
`define CBT_ERR_CODE   16'h1005
`define CBT_ERR_NONE   16'h0000
`endif

// >>> rtl/cbt_pkg.sv
// Types and shared checks of the consistent block transfer pair.
// Assumes cbt_defs.svh is on the include path.
package cbt_pkg;
`include "cbt_defs.svh"
  typedef logic [`CBT_WORD_W-1:0] cbt_word_t;
  typedef logic [`CBT_IDX_W-1:0]  cbt_idx_t;
  typedef enum logic [1:0] {CBT_OK, CBT_SKIP, CBT_ERR} cbt_stat_t;
  typedef enum logic [1:0] {CBT_R_IDLE, CBT_R_LOCK, CBT_R_COPY, CBT_R_DRAIN} cbt_rd_st_t;
  typedef enum logic [1:0] {CBT_W_IDLE, CBT_W_COLLECT, CBT_W_LOCK, CBT_W_COPY} cbt_wr_st_t;
  typedef enum logic [2:0] {CBT_H_IDLE, CBT_H_START, CBT_H_REQ, CBT_H_RUN, CBT_H_END} cbt_h_st_t;

  // Offset plus count must stay inside the area, count at least one
  function automatic logic cbt_range_ok(input cbt_word_t off, input cbt_word_t cnt);
    logic [16:0] sum;
    sum = {1'b0, off} + {1'b0, cnt};
    return (cnt != 16'h0000) && (sum <= 17'(`CBT_AREA_WORDS));
  endfunction
endpackage

// >>> rtl/cbt_if.sv
// Link between the host controller end and the slave module end.
// Both ends run on the same mclk; req and done are one-clock pulses, the rest are plain levels.
`timescale 1ns/1ps
interface cbt_if;
  import cbt_pkg::*;
  // Start requests and acceptance flags
  logic      rd_start_request;
  logic      rd_accept_complete;
  logic      wr_start_request;
  logic      wr_accept_complete;
  // Read command and answer
  logic      rd_req;
  logic [7:0] rd_module_select;
  cbt_word_t rd_head_offset;
  cbt_word_t rd_word_count;
  cbt_word_t rd_data;
  logic      rd_valid;
  logic      rd_ready;
  logic      rd_done;
  cbt_stat_t rd_stat;
  // Write command and answer
  logic      wr_req;
  logic [7:0] wr_module_select;
  cbt_word_t wr_head_offset;
  cbt_word_t wr_word_count;
  cbt_word_t wr_data;
  logic      wr_valid;
  logic      wr_ready;
  logic      wr_done;
  cbt_stat_t wr_stat;
  // Last operation error code
  cbt_word_t err_code;

  modport dev (input rd_start_request, wr_start_request, rd_req, rd_module_select,
               rd_head_offset, rd_word_count, rd_ready, wr_req, wr_module_select,
               wr_head_offset, wr_word_count, wr_data, wr_valid,
               output rd_accept_complete, wr_accept_complete, rd_data, rd_valid,
               rd_done, rd_stat, wr_ready, wr_done, wr_stat, err_code);
  modport host (output rd_start_request, wr_start_request, rd_req, rd_module_select,
                rd_head_offset, rd_word_count, rd_ready, wr_req, wr_module_select,
                wr_head_offset, wr_word_count, wr_data, wr_valid,
                input rd_accept_complete, wr_accept_complete, rd_data, rd_valid,
                rd_done, rd_stat, wr_ready, wr_done, wr_stat, err_code);
endinterface

// >>> rtl/cbt_dev.sv
// Slave module end: output receive area, input send area, block engines.
// Assumes the fieldbus side starts no frame while the matching lock is high.
// The read return FIFO module sits in the host end file.
`timescale 1ns/1ps
`include "cbt_defs.svh"

module cbt_dev import cbt_pkg::*; (
  // Link to the host controller
  cbt_if.dev              link,
  // Clock and reset
  input  wire logic       mclk,
  input  wire logic       resetn,
  // Configuration and module state
  input  wire logic [7:0] own_select,
  input  wire logic       auto_refresh_en,
  input  wire logic       separation_prevent_en,
  input  wire logic       consistency_running,
  input  wire logic       out_module_cfg,
  input  wire logic       in_module_cfg,
  // Fieldbus side, output receive area
  input  wire logic       bus_out_busy,
  input  wire logic       bus_out_we,
  input  wire cbt_idx_t   bus_out_addr,
  input  wire cbt_word_t  bus_out_data,
  output logic            recv_locked,
  // Fieldbus side, input send area
  input  wire logic       bus_in_busy,
  input  wire cbt_idx_t   bus_in_addr,
  output cbt_word_t       bus_in_data,
  output logic            send_locked
);
  cbt_word_t  recv_area [`CBT_AREA_WORDS];
  cbt_word_t  send_area [`CBT_AREA_WORDS];
  cbt_word_t  wr_stage  [`CBT_AREA_WORDS];
  logic       rd_acc_ff, wr_acc_ff;
  cbt_rd_st_t rd_st_ff;
  cbt_wr_st_t wr_st_ff;
  cbt_idx_t   rd_idx_ff, rd_off_ff, rd_cnt_ff;
  cbt_idx_t   wr_idx_ff, wr_off_ff, wr_cnt_ff;
  logic       rd_done_ff, wr_done_ff, wr_ready_ff;
  cbt_stat_t  rd_stat_ff, wr_stat_ff;
  logic       recv_locked_ff, send_locked_ff;
  cbt_word_t  bus_in_data_ff, err_code_ff;
  cbt_stat_t  rd_judge, wr_judge;
  logic       fifo_in_ready, fifo_out_valid, rd_push, rd_last, wr_take, wr_last;

  // Verdict on a request: no processing, operation error or go
  function automatic cbt_stat_t judge(input logic acc, input logic cfg,
                                      input logic [7:0] sel, input cbt_word_t off,
                                      input cbt_word_t cnt);
    if (!acc || consistency_running || (auto_refresh_en && separation_prevent_en)) begin
      return CBT_SKIP;
    end else if (sel > `CBT_SEL_MAX || !cbt_range_ok(off, cnt)) begin
      return CBT_ERR;
    end else if (!cfg || sel != own_select) begin
      return CBT_SKIP;
    end
    return CBT_OK;
  endfunction

  assign rd_judge = judge(rd_acc_ff, out_module_cfg, link.rd_module_select,
                          link.rd_head_offset, link.rd_word_count);
  assign wr_judge = judge(wr_acc_ff, in_module_cfg, link.wr_module_select,
                          link.wr_head_offset, link.wr_word_count);
  assign rd_push  = (rd_st_ff == CBT_R_COPY) && fifo_in_ready;
  assign rd_last  = (rd_idx_ff + 7'h01) == rd_cnt_ff;
  assign wr_take  = wr_ready_ff && link.wr_valid;
  assign wr_last  = (wr_idx_ff + 7'h01) == wr_cnt_ff;

  // Acceptance flags track the start requests
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      rd_acc_ff <= 1'b0;
      wr_acc_ff <= 1'b0;
    end else begin
      rd_acc_ff <= link.rd_start_request;
      wr_acc_ff <= link.wr_start_request;
    end
  end

  // Read engine, separate from the write engine
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      rd_st_ff       <= CBT_R_IDLE;
      rd_idx_ff      <= '0;
      rd_off_ff      <= '0;
      rd_cnt_ff      <= '0;
      rd_done_ff     <= 1'b0;
      rd_stat_ff     <= CBT_OK;
      recv_locked_ff <= 1'b0;
    end else begin
      rd_done_ff <= 1'b0;
      case (rd_st_ff)
        CBT_R_IDLE: begin
          if (link.rd_req) begin
            rd_stat_ff <= rd_judge;
            rd_off_ff  <= link.rd_head_offset[`CBT_IDX_W-1:0];
            rd_cnt_ff  <= link.rd_word_count[`CBT_IDX_W-1:0];
            rd_idx_ff  <= '0;
            if (rd_judge == CBT_OK) begin
              rd_st_ff       <= CBT_R_LOCK;
              recv_locked_ff <= 1'b1;
            end else begin
              rd_done_ff <= 1'b1;
            end
          end
        end
        CBT_R_LOCK: begin
          // Wait out a fieldbus update already under way
          if (!bus_out_busy) begin
            rd_st_ff <= CBT_R_COPY;
          end
        end
        CBT_R_COPY: begin
          if (rd_push) begin
            rd_idx_ff <= rd_idx_ff + 7'h01;
            if (rd_last) begin
              rd_st_ff       <= CBT_R_DRAIN;
              recv_locked_ff <= 1'b0;
            end
          end
        end
        default: begin
          if (!fifo_out_valid) begin
            rd_st_ff   <= CBT_R_IDLE;
            rd_done_ff <= 1'b1;
          end
        end
      endcase
    end
  end

  // Snapshot words pass through the FIFO to the host
  cbt_fifo #(.W(`CBT_WORD_W), .DEPTH(`CBT_FIFO_DEPTH)) u_rd_fifo (
    .mclk      (mclk),
    .resetn    (resetn),
    .in_valid  (rd_st_ff == CBT_R_COPY),
    .in_ready  (fifo_in_ready),
    .in_data   (recv_area[rd_off_ff + rd_idx_ff]),
    .out_valid (fifo_out_valid),
    .out_ready (link.rd_ready),
    .out_data  (link.rd_data)
  );

  // Write engine, separate from the read engine
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      wr_st_ff       <= CBT_W_IDLE;
      wr_idx_ff      <= '0;
      wr_off_ff      <= '0;
      wr_cnt_ff      <= '0;
      wr_done_ff     <= 1'b0;
      wr_stat_ff     <= CBT_OK;
      wr_ready_ff    <= 1'b0;
      send_locked_ff <= 1'b0;
    end else begin
      wr_done_ff <= 1'b0;
      case (wr_st_ff)
        CBT_W_IDLE: begin
          if (link.wr_req) begin
            wr_stat_ff <= wr_judge;
            wr_off_ff  <= link.wr_head_offset[`CBT_IDX_W-1:0];
            wr_cnt_ff  <= link.wr_word_count[`CBT_IDX_W-1:0];
            wr_idx_ff  <= '0;
            if (wr_judge == CBT_OK) begin
              wr_st_ff    <= CBT_W_COLLECT;
              wr_ready_ff <= 1'b1;
            end else begin
              wr_done_ff <= 1'b1;
            end
          end
        end
        CBT_W_COLLECT: begin
          // Gather the whole block before touching the send area
          if (wr_take) begin
            wr_idx_ff <= wr_idx_ff + 7'h01;
            if (wr_last) begin
              wr_st_ff       <= CBT_W_LOCK;
              wr_ready_ff    <= 1'b0;
              wr_idx_ff      <= '0;
              send_locked_ff <= 1'b1;
            end
          end
        end
        CBT_W_LOCK: begin
          if (!bus_in_busy) begin
            wr_st_ff <= CBT_W_COPY;
          end
        end
        default: begin
          wr_idx_ff <= wr_idx_ff + 7'h01;
          if (wr_last) begin
            wr_st_ff       <= CBT_W_IDLE;
            send_locked_ff <= 1'b0;
            wr_done_ff     <= 1'b1;
          end
        end
      endcase
    end
  end

  // Last error code, error wins over a clean verdict
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      err_code_ff <= `CBT_ERR_NONE;
    end else if ((link.rd_req && rd_st_ff == CBT_R_IDLE && rd_judge == CBT_ERR) ||
                 (link.wr_req && wr_st_ff == CBT_W_IDLE && wr_judge == CBT_ERR)) begin
      err_code_ff <= `CBT_ERR_CODE;
    end else if ((link.rd_req && rd_st_ff == CBT_R_IDLE && rd_judge == CBT_OK) ||
                 (link.wr_req && wr_st_ff == CBT_W_IDLE && wr_judge == CBT_OK)) begin
      err_code_ff <= `CBT_ERR_NONE;
    end
  end

  // Area storage and the fieldbus read port
  always_ff @(posedge mclk) begin
    if (bus_out_we && bus_out_addr < 7'(`CBT_AREA_WORDS)) begin
      recv_area[bus_out_addr] <= bus_out_data;
    end
    if (wr_take) begin
      wr_stage[wr_idx_ff] <= link.wr_data;
    end
    if (wr_st_ff == CBT_W_COPY) begin
      send_area[wr_off_ff + wr_idx_ff] <= wr_stage[wr_idx_ff];
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      bus_in_data_ff <= '0;
    end else if (bus_in_addr < 7'(`CBT_AREA_WORDS)) begin
      bus_in_data_ff <= send_area[bus_in_addr];
    end
  end

  // Output wiring
  assign link.rd_accept_complete = rd_acc_ff;
  assign link.wr_accept_complete = wr_acc_ff;
  assign link.rd_valid           = fifo_out_valid;
  assign link.rd_done            = rd_done_ff;
  assign link.rd_stat            = rd_stat_ff;
  assign link.wr_ready           = wr_ready_ff;
  assign link.wr_done            = wr_done_ff;
  assign link.wr_stat            = wr_stat_ff;
  assign link.err_code           = err_code_ff;
  assign recv_locked             = recv_locked_ff;
  assign send_locked             = send_locked_ff;
  assign bus_in_data             = bus_in_data_ff;
endmodule

// >>> sim/cbt_checker.sv
// Link checker for the consistent block transfer pair.
// Sees only the cbt_if signals; tb_top instantiates it beside the link.
`timescale 1ns/1ps
module cbt_checker import cbt_pkg::*; (
  // Clock and reset
  input wire logic      mclk,
  input wire logic      resetn,
  // Link signals
  input wire logic      rd_start_request,
  input wire logic      rd_accept_complete,
  input wire logic      wr_start_request,
  input wire logic      wr_accept_complete,
  input wire logic      rd_req,
  input wire logic      wr_req,
  input wire logic      rd_done,
  input wire logic      wr_done,
  input wire cbt_stat_t wr_stat,
  input wire cbt_word_t err_code,
  input wire logic      rd_valid,
  input wire logic      rd_ready,
  input wire cbt_word_t rd_data
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);

  // Acceptance flags trail their start requests by one clock
  property p_rd_acc; rd_accept_complete == $past(rd_start_request); endproperty
  a_rd_acc: assert property (p_rd_acc) else $error("read accept off");
  property p_wr_acc; wr_accept_complete == $past(wr_start_request); endproperty
  a_wr_acc: assert property (p_wr_acc) else $error("write accept off");
  // Requests only under raised and accepted start requests, read done only under a raised start request
  property p_rd_gate; rd_req |-> rd_start_request && rd_accept_complete; endproperty
  a_rd_gate: assert property (p_rd_gate) else $error("read not gated");
  property p_wr_gate; wr_req |-> wr_start_request && wr_accept_complete; endproperty
  a_wr_gate: assert property (p_wr_gate) else $error("write not gated");
  property p_rd_live; rd_done |-> rd_start_request; endproperty
  a_rd_live: assert property (p_rd_live) else $error("start dropped early");
  // Error code follows the verdict
  property p_err; wr_done && wr_stat == CBT_ERR |-> ##[0:1] err_code == 16'h1005; endproperty
  a_err: assert property (p_err) else $error("error code missing");
  property p_ok; wr_done && wr_stat == CBT_OK |-> ##[0:1] err_code == 16'h0000; endproperty
  a_ok: assert property (p_ok) else $error("error code stale");
  // Stalled read word holds
  property p_hold; rd_valid && !rd_ready |=> rd_valid && $stable(rd_data); endproperty
  a_hold: assert property (p_hold) else $error("read word lost");
endmodule

// >>> sim/tb_top.sv
// Testbench joining host end and slave end over cbt_if.
// Drives user sides at falling mclk edges and checks results.
`timescale 1ns/1ps
module tb_top import cbt_pkg::*;;
  logic      mclk = 0, resetn = 0, scan_tick, usr_rd_go, usr_wr_go, bus_out_we;
  logic      auto_refresh_en, separation_prevent_en, consistency_running, usr_wr_valid = 0;
  logic      out_module_cfg, in_module_cfg, out_module_present, in_module_present;
  logic      bus_out_busy, bus_in_busy, usr_rd_valid, usr_rd_done, usr_wr_ready, usr_wr_done;
  logic      recv_locked, send_locked;
  cbt_word_t usr_rd_off, usr_rd_cnt, usr_wr_off, usr_wr_cnt, usr_wr_data = 0, bus_out_data;
  cbt_word_t usr_rd_data, bus_in_data, rq[$], wq[$];
  cbt_idx_t  bus_out_addr, bus_in_addr;
  cbt_stat_t usr_rd_stat, usr_wr_stat;
  int        wi = 0, err_total = 0, n_compared = 0, lk_hi = 0, i;

  cbt_if lk ();
  cbt_dev cbt_dev_inst (.link(lk.dev), .own_select(8'h3a), .*);
  cbt_host cbt_host_inst (.link(lk.host), .head_io_num(12'h3a0), .usr_rd_ready(1'b1), .*);
  cbt_checker cbt_checker_inst (.mclk(mclk), .resetn(resetn),
    .rd_start_request(lk.rd_start_request), .rd_accept_complete(lk.rd_accept_complete),
    .wr_start_request(lk.wr_start_request), .wr_accept_complete(lk.wr_accept_complete),
    .rd_req(lk.rd_req), .wr_req(lk.wr_req), .rd_done(lk.rd_done), .wr_done(lk.wr_done),
    .wr_stat(lk.wr_stat), .err_code(lk.err_code), .rd_valid(lk.rd_valid),
    .rd_ready(lk.rd_ready), .rd_data(lk.rd_data));

  // Clock, read collector and write word feeder
  always #2.5 mclk = ~mclk;
  always @(posedge mclk) begin
    if (usr_rd_valid === 1'b1) rq.push_back(usr_rd_data);
    if (usr_wr_valid && usr_wr_ready === 1'b1) wi++;
    if (recv_locked === 1'b1 || send_locked === 1'b1) lk_hi++;
  end
  always @(negedge mclk) begin
    usr_wr_valid <= wi < wq.size();
    usr_wr_data  <= wi < wq.size() ? wq[wi] : 16'h0000;
  end

  task automatic chk(input string nm, input cbt_word_t got, input cbt_word_t exp);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %s exp %h got %h", nm, exp, got);
    end
  endtask

  // One block transfer in its own scan; dir 1 writes
  task automatic xfer(input bit dir, input cbt_word_t off, input cbt_word_t cnt,
                      input cbt_stat_t st);
    int n;
    rq = {};
    wq = {};
    wi = 0;
    lk_hi = 0;
    for (n = 0; n < cnt; n++) wq.push_back(cbt_word_t'(16'hc000 + off + n));
    if (!dir) wq = {};
    @(negedge mclk);
    scan_tick = 1;
    {usr_rd_off, usr_rd_cnt, usr_wr_off, usr_wr_cnt} = {off, cnt, off, cnt};
    if (dir) usr_wr_go = 1; else usr_rd_go = 1;
    @(negedge mclk);
    scan_tick = 0;
    while ((dir ? usr_wr_done : usr_rd_done) !== 1'b1) @(negedge mclk);
    {usr_rd_go, usr_wr_go} = 2'b00;
    chk("stat", cbt_word_t'(dir ? usr_wr_stat : usr_rd_stat), cbt_word_t'(st));
    chk("locked", cbt_word_t'(lk_hi != 0), cbt_word_t'(st == CBT_OK));
    if (st == CBT_ERR) chk("err_code", lk.err_code, 16'h1005);
    if (st == CBT_OK) chk("err_clear", lk.err_code, 16'h0000);
    if (!dir) chk("rd_cnt", cbt_word_t'(rq.size()), st == CBT_OK ? cnt : 16'h0000);
    for (n = 0; n < rq.size(); n++) chk("rd_word", rq[n], cbt_word_t'(16'h5000 + off + n));
    for (n = 0; dir && st == CBT_OK && n < cnt; n++) begin
      bus_in_addr = cbt_idx_t'(off + n);
      @(negedge mclk);
      chk("send_word", bus_in_data, cbt_word_t'(16'hc000 + off + n));
    end
    wq = {};
    repeat (6) @(negedge mclk);
    $display("test dir %0d off %0d cnt %0d done", dir, off, cnt);
  endtask

  task automatic report_and_stop;
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  // Watchdog against a hung handshake
  initial begin
    #60000;
    err_total++;
    report_and_stop();
  end

  // Main sequence
  initial begin
    {scan_tick, usr_rd_go, usr_wr_go, bus_out_we, bus_out_busy, bus_in_busy} = '0;
    {auto_refresh_en, separation_prevent_en, consistency_running} = '0;
    {out_module_cfg, in_module_cfg, out_module_present, in_module_present} = '1;
    {usr_rd_off, usr_rd_cnt, usr_wr_off, usr_wr_cnt, bus_out_data} = '0;
    {bus_out_addr, bus_in_addr} = '0;
    repeat (3) @(posedge mclk);
    @(negedge mclk) resetn = 1;
    for (i = 0; i < 122; i++) begin
      @(negedge mclk);
      {bus_out_we, bus_out_addr, bus_out_data} = {1'b1, cbt_idx_t'(i), 16'h5000 + i[15:0]};
    end
    @(negedge mclk) bus_out_we = 0;
    xfer(0, 118, 4, CBT_OK);
    xfer(0, 119, 4, CBT_ERR);
    xfer(0, 0, 0, CBT_ERR);
    consistency_running = 1;
    xfer(0, 0, 2, CBT_SKIP);
    {consistency_running, auto_refresh_en, separation_prevent_en} = 3'b011;
    xfer(0, 0, 2, CBT_SKIP);
    xfer(1, 0, 1, CBT_SKIP);
    separation_prevent_en = 0;
    xfer(0, 3, 2, CBT_OK);
    {auto_refresh_en, out_module_cfg} = 2'b00;
    xfer(0, 0, 1, CBT_SKIP);
    {out_module_cfg, out_module_present} = 2'b10;
    xfer(0, 0, 1, CBT_SKIP);
    {out_module_present, in_module_cfg} = 2'b10;
    xfer(1, 0, 1, CBT_SKIP);
    in_module_cfg = 1;
    xfer(1, 120, 2, CBT_OK);
    xfer(1, 121, 2, CBT_ERR);
    report_and_stop();
  end
endmodule
